/* verilog/lku_top.sv */
// card lock/unlock decoder: parses the command data block, checks the
// passcode, updates lock state and reports the two card status bits
// assumes the data block arrives one byte per data_valid, framed by
// cmd_start before it and data_last on its final byte
//
// Summary of operation
// (RQ1) request byte: bit3 erase, bit2 lock, bit1 clear passcode, bit0 set passcode
// (RQ2) request byte bits 7 to 4 are ignored when decoding
// (RQ3) host must send a block at least as long as the data structure
// (RQ4) passcode length of zero or above 128 bits is an error
// (RQ5) wrong old or new passcode is an error for any passcode function
// (RQ6) any error sets the failed flag, whatever the function result
// (RQ7) response locked bit shows the state before the command
// (RQ8) a lock change shows in the next status query
// (RQ9) failed flag shows in own response or next status query
// (RQ10) after reset: locked if passcode stored, unlocked if not, not failed
// (RQ11) lock plus set while locked with passcode: replace, stay locked
// (RQ12) lock plus set while unlocked with passcode: replace and lock
// (RQ13) lock plus set while unlocked without passcode: store and lock
// (RQ14) clear alone while locked: drop passcode and unlock
// (RQ15) clear alone while unlocked with passcode: drop passcode, stay unlocked
// (RQ16) clear alone while unlocked without passcode: fail
// (RQ17) set alone with stored passcode: replace it and leave unlocked
// (RQ18) set alone unlocked without passcode: store it, stay unlocked
// (RQ19) any other request combination is an error
// (RQ20) erase alone works only locked with passcode; unlocked it fails
// (RQ21) lock alone while unlocked needs matching passcode, else fails
// (RQ22) no request bits while locked unlocks on matching passcode, else fails
// (RQ23) locking a locked card or one without passcode fails
// (RQ24) unlocking an unlocked card fails
`timescale 1ns/1ps
`default_nettype none

module lku_top (
	// clock and reset
	input  wire logic                       clk,
	input  wire logic                       rstn,
	// card reset command
	input  wire logic                       soft_reset,
	// command data block
	input  wire logic                       cmd_start,
	input  wire logic                       data_valid,
	input  wire logic [lku_pkg::BYTE_W-1:0] data_byte,
	input  wire logic                       data_last,
	// erase engine handshake
	output logic                            force_erase_req,
	input  wire logic                       force_erase_done,
	// status query and results
	input  wire logic                       status_query,
	output logic                            busy,
	output logic                            resp_valid,
	output logic                            resp_locked,
	output logic                            resp_failed,
	output logic                            locked_state_flag,
	output logic                            lock_op_failed_flag,
	output logic [7:0]                      passcode_length
);
	import lku_pkg::*;

	lku_dec_if dif ();
	lku_pw_if  pif ();

	lku_state_e state_ff;
	lku_state_e nxt_state;
	lku_func_e  func_ff;
	logic [7:0] len_ff;
	logic [7:0] cnt_ff;
	logic       mis_ff;
	logic       short_ff;
	logic       locked_ff;
	logic       failed_ff;
	logic       resp_valid_ff;
	logic       resp_locked_ff;
	logic       resp_failed_ff;
	logic       erase_req_ff;

	logic       has_pw;
	logic       in_old;
	logic [7:0] offs;
	logic [7:0] new_len;
	logic       byte_take;
	logic       exec_err;
	logic       exec_ok;
	logic       erase_end;

	lku_func_dec i_lku_func_dec (
		.dif (dif.dec)
	);

	lku_pw_store #(
		.BYTES (PW_MAX_BYTES)
	) i_lku_pw_store (
		.clk  (clk),
		.rstn (rstn),
		.pif  (pif.store)
	);

	// decode inputs; only the low nibble reaches the decoder
	assign has_pw     = (pif.len != LEN_NONE);
	assign dif.req    = data_byte[REQ_W-1:0];  // RQ1 RQ2
	assign dif.locked = locked_ff;
	assign dif.has_pw = has_pw;

	// byte routing: the first stored-length bytes are the old passcode
	assign in_old    = (cnt_ff < pif.len);
	assign offs      = cnt_ff - pif.len;
	assign byte_take = (state_ff == ST_DATA) && data_valid && (cnt_ff < len_ff);
	assign pif.idx   = in_old ? cnt_ff[IDX_W-1:0] : offs[IDX_W-1:0];
	assign pif.data  = data_byte;
	assign pif.stage_we = byte_take && !in_old && lku_is_set(func_ff)
		&& (offs < PW_MAX_LEN);
	assign new_len   = len_ff - pif.len;

	// error checks at execution; length and content both have to agree
	always_comb begin
		exec_err = short_ff || (func_ff == FN_ERROR);  // RQ19
		if (lku_needs_match(func_ff)) begin
			exec_err = exec_err || (len_ff == LEN_NONE) || (len_ff > PW_MAX_LEN)  // RQ4
				|| (len_ff != pif.len) || mis_ff;  // RQ5
		end
		if (lku_is_set(func_ff)) begin
			exec_err = exec_err || (len_ff < pif.len) || (new_len == LEN_NONE)  // RQ4
				|| (new_len > PW_MAX_LEN) || mis_ff;  // RQ5
		end
	end

	// a card reset in the same cycle wins, so no half-done update survives it
	assign exec_ok   = (state_ff == ST_EXEC) && !exec_err && !soft_reset;
	assign erase_end = (state_ff == ST_ERASE) && force_erase_done && !soft_reset;

	// store updates: commit new passcode, or drop it on clear or erase
	assign pif.commit  = exec_ok && lku_is_set(func_ff);  // RQ11 RQ12 RQ13 RQ17 RQ18
	assign pif.new_len = new_len;
	assign pif.clr     = (exec_ok && (func_ff == FN_CLEAR)) || erase_end;  // RQ14 RQ15

	// sequencing; a short block ends the command early as an error
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (cmd_start)
					nxt_state = ST_MODE;
			end
			ST_MODE, ST_LEN: begin
				if (data_valid && data_last)
					nxt_state = ST_EXEC;
				else if (data_valid)
					nxt_state = (state_ff == ST_MODE) ? ST_LEN : ST_DATA;
			end
			ST_DATA: begin
				if (data_valid && data_last)
					nxt_state = ST_EXEC;
			end
			ST_EXEC: begin
				nxt_state = (exec_ok && (func_ff == FN_FORCE_ERASE)) ? ST_ERASE : ST_IDLE;
			end
			ST_ERASE: begin
				if (force_erase_done)
					nxt_state = ST_IDLE;
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	// card reset aborts any command in flight
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			state_ff <= ST_IDLE;
		else if (soft_reset)
			state_ff <= ST_IDLE;
		else
			state_ff <= nxt_state;
	end

	// function fixed from the request byte and the state at that moment
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			func_ff <= FN_ERROR;
			len_ff  <= LEN_NONE;
		end else if (state_ff == ST_MODE && data_valid) begin
			func_ff <= dif.func;
			len_ff  <= LEN_NONE;
		end else if (state_ff == ST_LEN && data_valid) begin
			len_ff <= data_byte;
		end
	end

	// byte counter and sticky compare / short-block flags
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_ff   <= LEN_NONE;
			mis_ff   <= 1'b0;
			short_ff <= 1'b0;
		end else if (state_ff == ST_IDLE) begin
			cnt_ff   <= LEN_NONE;
			mis_ff   <= 1'b0;
			short_ff <= 1'b0;
		end else begin
			if (byte_take)
				cnt_ff <= cnt_ff + CNT_ONE;
			if (byte_take && in_old && !pif.match)
				mis_ff <= 1'b1;  // RQ5
			// too short a block leaves the outcome open; treat it as failure
			// a zero length may end on the length byte (force erase needs no passcode)
			if (data_valid && data_last && ((state_ff == ST_MODE)
				|| (state_ff == ST_LEN && data_byte != LEN_NONE)
				|| (state_ff == ST_DATA && (cnt_ff + CNT_ONE) < len_ff)))
				short_ff <= 1'b1;  // RQ3
		end
	end

	// lock state; card reset relocks a card holding a passcode
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			locked_ff <= 1'b0;  // RQ10
		end else if (soft_reset) begin
			locked_ff <= has_pw;  // RQ10
		end else if (exec_ok) begin
			case (func_ff)
				FN_LOCK, FN_SET_LOCK: locked_ff <= 1'b1;  // RQ12 RQ13 RQ21
				FN_UNLOCK, FN_SET_UNLOCK, FN_CLEAR: locked_ff <= 1'b0;  // RQ14 RQ17 RQ22
				default: locked_ff <= locked_ff;
			endcase
		end else if (erase_end) begin
			locked_ff <= 1'b0;  // RQ20
		end
	end

	// response pulse carries the state held before the command
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			resp_valid_ff  <= 1'b0;
			resp_locked_ff <= 1'b0;
			resp_failed_ff <= 1'b0;
		end else begin
			resp_valid_ff <= !soft_reset && (((state_ff == ST_EXEC) && !exec_ok)
				|| (exec_ok && func_ff != FN_FORCE_ERASE) || erase_end);
			if (state_ff == ST_EXEC) begin
				resp_locked_ff <= locked_ff;  // RQ7
				resp_failed_ff <= exec_err;  // RQ6 RQ9
			end
		end
	end

	// failed flag holds until a status query has read it; a new failure wins
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			failed_ff <= 1'b0;
		else if (soft_reset)
			failed_ff <= 1'b0;  // RQ10
		else if (state_ff == ST_EXEC && exec_err)
			failed_ff <= 1'b1;  // RQ6 RQ9
		else if (status_query)
			failed_ff <= 1'b0;
	end

	// erase request stands until the engine reports done
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			erase_req_ff <= 1'b0;
		else if (soft_reset || erase_end)
			erase_req_ff <= 1'b0;
		else if (exec_ok && func_ff == FN_FORCE_ERASE)
			erase_req_ff <= 1'b1;  // RQ20
	end

	assign busy                = (state_ff != ST_IDLE);
	assign resp_valid          = resp_valid_ff;
	assign resp_locked         = resp_locked_ff;
	assign resp_failed         = resp_failed_ff;
	assign locked_state_flag   = locked_ff;  // RQ8
	assign lock_op_failed_flag = failed_ff;
	assign passcode_length     = pif.len;
	assign force_erase_req     = erase_req_ff;

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence s_exec_plain;
		(state_ff == ST_EXEC) && !soft_reset && !(exec_ok && func_ff == FN_FORCE_ERASE);
	endsequence

	sequence s_resp_fail;
		resp_valid && resp_failed && lock_op_failed_flag;
	endsequence

	property p_bad_len;
		s_exec_plain ##0 (lku_needs_match(func_ff) && (len_ff == LEN_NONE
			|| len_ff > PW_MAX_LEN)) |=> s_resp_fail;
	endproperty
	a_bad_len: assert property (p_bad_len) else $error("bad length not failed"); // RQ4

	property p_mismatch;
		s_exec_plain ##0 (mis_ff && func_ff != FN_ERROR) |=> s_resp_fail;
	endproperty
	a_mismatch: assert property (p_mismatch) else $error("mismatch not failed"); // RQ5

	property p_fail_keeps_state;
		s_exec_plain ##0 exec_err |=> s_resp_fail ##0 $stable(locked_state_flag)
			##0 $stable(passcode_length);
	endproperty
	a_fail_keeps_state: assert property (p_fail_keeps_state) else $error("failure changed state"); // RQ6

	property p_resp_prior;
		s_exec_plain |=> resp_valid && (resp_locked == $past(locked_state_flag));
	endproperty
	a_resp_prior: assert property (p_resp_prior) else $error("response lock bit wrong"); // RQ7

	property p_set_lock;
		s_exec_plain ##0 (!exec_err && func_ff == FN_SET_LOCK)
			|=> locked_state_flag && passcode_length == $past(new_len);
	endproperty
	a_set_lock: assert property (p_set_lock) else $error("set and lock failed"); // RQ12

	property p_failed_held;
		lock_op_failed_flag && !status_query && !soft_reset |=> lock_op_failed_flag;
	endproperty
	a_failed_held: assert property (p_failed_held) else $error("failed flag lost"); // RQ9

	property p_card_reset;
		soft_reset |=> !lock_op_failed_flag && !busy
			&& (locked_state_flag == (passcode_length != LEN_NONE));
	endproperty
	a_card_reset: assert property (p_card_reset) else $error("reset state wrong"); // RQ10

	property p_clear;
		s_exec_plain ##0 (!exec_err && func_ff == FN_CLEAR)
			|=> !locked_state_flag && passcode_length == LEN_NONE;
	endproperty
	a_clear: assert property (p_clear) else $error("clear did not unlock"); // RQ14

	property p_bad_func;
		s_exec_plain ##0 (func_ff == FN_ERROR) |=> s_resp_fail ##1 !resp_valid;
	endproperty
	a_bad_func: assert property (p_bad_func) else $error("bad request not failed"); // RQ19

	property p_erase;
		(state_ff == ST_EXEC) && exec_ok && (func_ff == FN_FORCE_ERASE) && !soft_reset
			|=> force_erase_req && !resp_valid;
	endproperty
	a_erase: assert property (p_erase) else $error("erase not requested"); // RQ20

endmodule

`default_nettype wire

/* verilog/lku_pkg.sv */
// constants, types and helpers shared by the card lock/unlock decoder files
// assumes a single 25 MHz clock domain; no bus, every control bit is a port
package lku_pkg;

	// parameter byte layout: request flags in the low nibble
	localparam int unsigned BYTE_W      = 8;
	localparam int unsigned REQ_W       = 4;
	localparam int unsigned BIT_ERASE   = 3;
	localparam int unsigned BIT_LOCK    = 2;
	localparam int unsigned BIT_CLEAR   = 1;
	localparam int unsigned BIT_SET     = 0;

	// request codes after the upper nibble is dropped
	localparam logic [3:0] REQ_UNLOCK   = 4'h0;
	localparam logic [3:0] REQ_SET      = 4'h1;
	localparam logic [3:0] REQ_CLEAR    = 4'h2;
	localparam logic [3:0] REQ_LOCK     = 4'h4;
	localparam logic [3:0] REQ_SET_LOCK = 4'h5;
	localparam logic [3:0] REQ_ERASE    = 4'h8;

	// passcode limits
	localparam int unsigned PW_MAX_BITS  = 128;
	localparam int unsigned PW_MAX_BYTES = PW_MAX_BITS / BYTE_W;
	localparam int unsigned IDX_W        = $clog2(PW_MAX_BYTES);
	localparam logic [7:0]  PW_MAX_LEN   = 8'(PW_MAX_BYTES);
	localparam logic [7:0]  LEN_NONE     = 8'h00;
	localparam logic [7:0]  BYTE_ZERO    = 8'h00;
	localparam logic [7:0]  CNT_ONE      = 8'h01;

	// decoded function of one command
	typedef enum logic [2:0] {
		FN_ERROR,
		FN_FORCE_ERASE,
		FN_LOCK,
		FN_UNLOCK,
		FN_SET_LOCK,
		FN_SET_UNLOCK,
		FN_CLEAR
	} lku_func_e;

	// command sequencing
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_MODE,
		ST_LEN,
		ST_DATA,
		ST_EXEC,
		ST_ERASE
	} lku_state_e;

	// functions that need the sent passcode to equal the stored one exactly
	function automatic logic lku_needs_match(input lku_func_e f);
		return (f == FN_LOCK) || (f == FN_UNLOCK) || (f == FN_CLEAR);
	endfunction

	// functions that load a new passcode
	function automatic logic lku_is_set(input lku_func_e f);
		return (f == FN_SET_LOCK) || (f == FN_SET_UNLOCK);
	endfunction

endpackage

/* verilog/lku_ifs.sv */
// carriers between the decoder top and its two helper modules
// assumes all ends share one clock; these are plain bundles, no logic
`timescale 1ns/1ps
`default_nettype none

// request decode: top drives the inputs, decoder answers combinationally
interface lku_dec_if;
	logic [lku_pkg::REQ_W-1:0] req;
	logic                      locked;
	logic                      has_pw;
	lku_pkg::lku_func_e        func;
	modport ctl (output req, output locked, output has_pw, input func);
	modport dec (input req, input locked, input has_pw, output func);
endinterface

// passcode store: compare old bytes, stage new bytes, commit or clear
interface lku_pw_if;
	logic [lku_pkg::IDX_W-1:0]  idx;
	logic [lku_pkg::BYTE_W-1:0] data;
	logic                       stage_we;
	logic                       commit;
	logic [7:0]                 new_len;
	logic                       clr;
	logic [7:0]                 len;
	logic                       match;
	modport ctl (output idx, output data, output stage_we, output commit,
		output new_len, output clr, input len, input match);
	modport store (input idx, input data, input stage_we, input commit,
		input new_len, input clr, output len, output match);
endinterface

`default_nettype wire

/* verilog/lku_func_dec.sv */
// request decoder: maps request nibble and card state to one function
// assumes the caller has already dropped the upper parameter bits
`timescale 1ns/1ps
`default_nettype none

module lku_func_dec (
	// decode request and answer
	lku_dec_if.dec dif
);
	import lku_pkg::*;

	// one table; a locked card without a passcode cannot arise, so it errors
	always_comb begin
		dif.func = FN_ERROR;
		case (dif.req)
			REQ_ERASE: begin
				if (dif.locked && dif.has_pw)  // RQ20
					dif.func = FN_FORCE_ERASE;
			end
			REQ_LOCK: begin
				if (!dif.locked && dif.has_pw)  // RQ21 RQ23
					dif.func = FN_LOCK;
			end
			REQ_SET_LOCK: begin
				if (dif.has_pw || !dif.locked)  // RQ11 RQ12 RQ13
					dif.func = FN_SET_LOCK;
			end
			REQ_CLEAR: begin
				if (dif.has_pw)  // RQ14 RQ15 RQ16
					dif.func = FN_CLEAR;
			end
			REQ_SET: begin
				if (dif.has_pw || !dif.locked)  // RQ17 RQ18
					dif.func = FN_SET_UNLOCK;
			end
			REQ_UNLOCK: begin
				if (dif.locked && dif.has_pw)  // RQ22 RQ24
					dif.func = FN_UNLOCK;
			end
			default: begin
				dif.func = FN_ERROR;  // RQ19
			end
		endcase
	end

endmodule

`default_nettype wire

/* verilog/lku_pw_store.sv */
// passcode store: active copy, staging copy for a new passcode, length
// assumes commit and clr are never raised in the same cycle
`timescale 1ns/1ps
`default_nettype none

module lku_pw_store #(
	parameter int unsigned BYTES = lku_pkg::PW_MAX_BYTES
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// control from the decoder top
	lku_pw_if.store  pif
);
	import lku_pkg::*;

	logic [BYTE_W-1:0] pw_ff    [BYTES];
	logic [BYTE_W-1:0] stage_ff [BYTES];
	logic [7:0]        len_ff;

	// staging keeps the old passcode intact until the command proves good
	for (genvar g = 0; g < BYTES; g++) begin : g_byte
		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn) begin
				stage_ff[g] <= BYTE_ZERO;
			end else if (pif.stage_we && (pif.idx == IDX_W'(g))) begin
				stage_ff[g] <= pif.data;
			end
		end

		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn) begin
				pw_ff[g] <= BYTE_ZERO;
			end else if (pif.clr) begin
				pw_ff[g] <= BYTE_ZERO;
			end else if (pif.commit) begin
				pw_ff[g] <= (g < pif.new_len) ? stage_ff[g] : BYTE_ZERO;
			end
		end
	end

	// length zero means no passcode is stored
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			len_ff <= LEN_NONE;
		end else if (pif.clr) begin
			len_ff <= LEN_NONE;
		end else if (pif.commit) begin
			len_ff <= pif.new_len;
		end
	end

	assign pif.len   = len_ff;
	assign pif.match = (pw_ff[pif.idx] == pif.data);

endmodule

`default_nettype wire

/* sim/lku_host.sv */
// host controller model: sends lock/unlock blocks, queries status and
// plays the erase engine; assumes it shares the decoder's only clock
`timescale 1ns/1ps
`default_nettype none

module lku_host (
	// clock
	input  wire logic       clk,
	// command block
	output logic            cmd_start,
	output logic            data_valid,
	output logic [7:0]      data_byte,
	output logic            data_last,
	output logic            status_query,
	// erase engine
	input  wire logic       force_erase_req,
	output logic            force_erase_done,
	// results
	input  wire logic       resp_valid,
	input  wire logic       resp_locked,
	input  wire logic       resp_failed
);
	int erase_wait = 0;
	int erase_cnt  = 0;

	// idle levels at time zero
	initial begin
		cmd_start        = 1'b0;
		data_valid       = 1'b0;
		data_byte        = 8'h00;
		data_last        = 1'b0;
		status_query     = 1'b0;
		force_erase_done = 1'b0;
	end

	// erase engine: answers promptly or after erase_wait cycles
	always @(negedge clk) begin
		force_erase_done = 1'b0;
		if (force_erase_req === 1'b1) begin
			if (erase_cnt >= erase_wait) begin
				force_erase_done = 1'b1;
				erase_cnt        = 0;
			end else begin
				erase_cnt++;
			end
		end
	end

	// whole block: request byte, length byte, then every passcode byte
	task automatic send(input logic [7:0] req, input logic [7:0] len,
		input logic [7:0] pw[$], output logic rl, output logic rf, output bit ok);
		logic [7:0] blk[$];
		blk = pw;
		blk.push_front(len);
		blk.push_front(req);
		ok  = 1'b0;
		@(negedge clk);
		cmd_start = 1'b1;
		@(negedge clk);
		cmd_start = 1'b0;
		for (int i = 0; i < blk.size(); i++) begin
			data_valid = 1'b1;
			data_byte  = blk[i];
			data_last  = (i == blk.size() - 1);
			@(negedge clk);
		end
		// released data lines must not keep showing the last byte
		data_valid = 1'b0;
		data_last  = 1'b0;
		data_byte  = ~data_byte;
		for (int n = 0; n < 64; n++) begin
			if (resp_valid === 1'b1) begin
				rl = resp_locked;
				rf = resp_failed;
				ok = 1'b1;
				break;
			end
			@(negedge clk);
		end
	endtask

	// one status read
	task automatic query();
		@(negedge clk);
		status_query = 1'b1;
		@(negedge clk);
		status_query = 1'b0;
	endtask
endmodule

`default_nettype wire

/* sim/card_lock_unlock_decoder_tb.sv */
// self-checking bench for the lock/unlock decoder top
// assumes the host model drives the command inputs at falling edges
`timescale 1ns/1ps
`default_nettype none

module card_lock_unlock_decoder_tb;
	import lku_pkg::*;

	logic       clk        = 1'b0;
	logic       rstn       = 1'b0;
	logic       soft_reset = 1'b0;
	logic       cmd_start, data_valid, data_last, status_query, busy;
	logic       force_erase_req, force_erase_done, resp_valid, resp_locked;
	logic       resp_failed, locked_state_flag, lock_op_failed_flag;
	logic [7:0] data_byte, passcode_length;
	int         n_fail      = 0;
	int         comparisons = 0;
	logic [7:0] pa[$], pb[$], px[$], pab[$], pba[$], nil[$], p17[$];
	logic [7:0] bad[10] = '{8'h03, 8'h06, 8'h07, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D,
		8'h0E, 8'h0F};

	// 25 MHz
	always #20 clk = ~clk;

	lku_top i_lku_top (.clk(clk), .rstn(rstn), .soft_reset(soft_reset),
		.cmd_start(cmd_start), .data_valid(data_valid), .data_byte(data_byte),
		.data_last(data_last), .force_erase_req(force_erase_req),
		.force_erase_done(force_erase_done), .status_query(status_query), .busy(busy),
		.resp_valid(resp_valid), .resp_locked(resp_locked), .resp_failed(resp_failed),
		.locked_state_flag(locked_state_flag),
		.lock_op_failed_flag(lock_op_failed_flag), .passcode_length(passcode_length));

	lku_host i_lku_host (.clk(clk), .cmd_start(cmd_start), .data_valid(data_valid),
		.data_byte(data_byte), .data_last(data_last), .status_query(status_query),
		.force_erase_req(force_erase_req), .force_erase_done(force_erase_done),
		.resp_valid(resp_valid), .resp_locked(resp_locked), .resp_failed(resp_failed));

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// current state against expectation: {locked, failed} and length
	task automatic state(input logic [1:0] lf, input logic [7:0] plen);
		check("locked_state_flag", 8'(locked_state_flag), 8'(lf[1]));
		check("lock_op_failed_flag", 8'(lock_op_failed_flag), 8'(lf[0]));
		check("passcode_length", passcode_length, plen);
	endtask

	// one command; exp is {resp locked, resp failed, locked after}
	task automatic cmd(input logic [7:0] req, input logic [7:0] len, input logic [7:0] pw[$],
		input logic [2:0] exp, input logic [7:0] plen);
		logic s_rl;
		logic s_rf;
		bit   ok;
		i_lku_host.send(req, len, pw, s_rl, s_rf, ok);
		if (!ok) begin
			check("resp_valid", 8'h00, 8'h01);
			wrap_up();
		end else begin
			check("resp_locked", 8'(s_rl), 8'(exp[2]));
			check("resp_failed", 8'(s_rf), 8'(exp[1]));
			check("busy", 8'(busy), 8'h00);
			state({exp[0], exp[1]}, plen);
			// failures stay sticky until a status read clears them
			if (exp[1]) begin
				i_lku_host.query();
				check("lock_op_failed_flag", 8'(lock_op_failed_flag), 8'h00);
			end
		end
	endtask

	initial begin
		pa  = '{8'hA1, 8'hA2};
		pb  = '{8'hB1, 8'hB2, 8'hB3};
		px  = '{8'hB1, 8'hB2, 8'hB4};
		pab = {pa, pb};
		pba = {pb, pa};
		for (int i = 0; i < 17; i++) begin
			p17.push_back(8'(i));
		end
		repeat (3) @(negedge clk);
		rstn = 1'b1;
		state(2'b00, 8'h00);
		$display("test reset done");

		cmd(8'h00, 8'h02, pa, 3'b010, 8'h00);
		cmd(8'h02, 8'h02, pa, 3'b010, 8'h00);
		cmd(8'h04, 8'h02, pa, 3'b010, 8'h00);
		cmd(8'h01, 8'h00, nil, 3'b010, 8'h00);
		cmd(8'h01, 8'h11, p17, 3'b010, 8'h00);
		foreach (bad[k]) begin
			cmd(bad[k], 8'h02, pa, 3'b010, 8'h00);
		end
		cmd(8'h08, 8'h00, nil, 3'b010, 8'h00);
		$display("test no passcode done");

		cmd(8'h01, 8'h02, pa, 3'b000, 8'h02);
		cmd(8'h08, 8'h00, nil, 3'b010, 8'h02);
		cmd(8'hF1, 8'h05, pab, 3'b000, 8'h03);
		cmd(8'h04, 8'h03, px, 3'b010, 8'h03);
		cmd(8'h00, 8'h03, pb, 3'b010, 8'h03);
		cmd(8'h04, 8'h03, pb, 3'b001, 8'h03);
		cmd(8'h04, 8'h03, pb, 3'b111, 8'h03);
		cmd(8'h00, 8'h02, pa, 3'b111, 8'h03);
		$display("test lock done");

		cmd(8'h05, 8'h05, pba, 3'b101, 8'h02);
		cmd(8'h00, 8'h02, pa, 3'b100, 8'h02);
		cmd(8'h05, 8'h05, pab, 3'b001, 8'h03);
		cmd(8'h02, 8'h03, pb, 3'b100, 8'h00);
		cmd(8'h05, 8'h02, pa, 3'b001, 8'h02);
		cmd(8'h01, 8'h05, pab, 3'b100, 8'h03);
		cmd(8'h02, 8'h03, pb, 3'b000, 8'h00);
		$display("test passcode change done");

		// erase engine answering at once, then slowly
		cmd(8'h05, 8'h02, pa, 3'b001, 8'h02);
		cmd(8'h08, 8'h00, nil, 3'b100, 8'h00);
		i_lku_host.erase_wait = 6;
		cmd(8'h05, 8'h02, pa, 3'b001, 8'h02);
		cmd(8'h78, 8'h00, nil, 3'b100, 8'h00);
		check("force_erase_req", 8'(force_erase_req), 8'h00);
		$display("test erase done");

		// card reset relocks a stored passcode, power-on drops it
		cmd(8'h01, 8'h02, pa, 3'b000, 8'h02);
		soft_reset = 1'b1;
		@(negedge clk);
		soft_reset = 1'b0;
		state(2'b10, 8'h02);
		cmd(8'h00, 8'h02, pa, 3'b100, 8'h02);
		rstn = 1'b0;
		@(negedge clk);
		rstn = 1'b1;
		state(2'b00, 8'h00);
		$display("test resets done");
		wrap_up();
	end
endmodule

`default_nettype wire
